// file: src/cpc_map.vh
// Register map, field positions, reset values and timing counts
// Assumes a 100 MHz system clock and a plain address/strobe register port
`ifndef CPC_MAP_VH
`define CPC_MAP_VH
`define CPC_ADDR_POWER_CONFIG 10'h000
`define CPC_ADDR_CAL_ENABLE 10'h001
`define CPC_RESET_POWER_CONFIG 16'h0000
`define CPC_RESET_CAL_ENABLE 16'h0000
`define CPC_POWER_CONFIG_MASK 16'hdfff
`define CPC_F_MODE_LO 0
`define CPC_F_MODE_HI 1
`define CPC_F_DELAY_LO 2
`define CPC_F_DELAY_HI 3
`define CPC_F_STAGES_LO 4
`define CPC_F_STAGES_HI 7
`define CPC_F_DECIM_LO 8
`define CPC_F_DECIM_HI 9
`define CPC_F_RESTORE 10
`define CPC_F_POLARITY 11
`define CPC_F_EXC_GATE 12
`define CPC_F_BIAS_LO 14
`define CPC_F_BIAS_HI 15
`define CPC_F_FPSKIP_LO 12
`define CPC_F_FPSKIP_HI 13
`define CPC_F_LPSKIP_LO 14
`define CPC_F_LPSKIP_HI 15
`define CPC_MODE_FULL 2'h0
`define CPC_MODE_LOW 2'h2
`define CPC_MAX_STAGE_CODE 4'hb
`define CPC_CLOCK_MHZ 100
`define CPC_FULL_INTERVAL_MS 36
`define CPC_LOW_DELAY_STEP_MS 200
`define CPC_CYCLES_PER_MS (`CPC_CLOCK_MHZ * 1000)
`define CPC_FULL_INTERVAL_CYC (`CPC_FULL_INTERVAL_MS * `CPC_CYCLES_PER_MS)
`define CPC_LOW_STEP_CYC (`CPC_LOW_DELAY_STEP_MS * `CPC_CYCLES_PER_MS)
`endif

// file: src/cpc_interval_timer.v
// Interval timer: pulses once every load_count cycles while running
// Assumes load_count is stable while run is high; restarts when run drops
`timescale 1ns/1ps
module cpc_interval_timer #(
   parameter WIDTH = 30
) (
   input wire clock,
   input wire rst,
   input wire run,
   input wire [WIDTH-1:0] load_count,
   output reg tick
);
   reg [WIDTH-1:0] count;
   // Count down, reload on expiry
   always @(posedge clock) begin
      if (rst || !run) begin
         count <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (count == {WIDTH{1'b0}}) begin
         count <= load_count - {{(WIDTH-1){1'b0}}, 1'b1};
         tick <= 1'b1;
      end else begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule // cpc_interval_timer

// file: src/cpc_power_config.v
// Power and calibration configuration for a capacitance converter
// Assumes a single 100 MHz clock and a synchronous, active-high reset
//
// Contract
// (R01) Mode 00 runs conversion sequences continuously about every 36 ms.
// (R02) Mode 01 or 11 shuts the converter down with no conversions.
// (R03) Mode 10 is low power, waking automatically to convert.
// (R04) In low power the wake delay is 200, 400, 600 or 800 ms by a two-bit field.
// (R05) The stage count is the four-bit field plus one, at most code 1011, twelve stages.
// (R06) Decimation is 256 for 00, 128 for 01 and 64 for 10 or 11.
// (R07) Writing 1 to the restore bit returns all registers to default and the bit clears.
// (R08) Polarity bit 0 makes the interrupt active low, 1 active high, low after reset.
// (R09) The gate bit 0 drives excitation onto the sensor pins, 1 withholds it.
// (R10) The bias field picks normal, plus 20, plus 35 or plus 50 percent.
// (R11) Each of twelve low enable bits turns on calibration for its stage, all off at reset.
// (R12) In full power the skip field skips 3, 7, 15 or 31 samples.
// (R13) In low power the skip field uses all samples, skips one or skips two.
`timescale 1ns/1ps
`include "cpc_map.vh"
module cpc_power_config #(
   parameter FULL_INTERVAL_CYC = `CPC_FULL_INTERVAL_CYC,
   parameter LOW_STEP_CYC = `CPC_LOW_STEP_CYC,
   parameter NUM_STAGES = 12
) (
   input wire clock,
   input wire rst,
   input wire [9:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   input wire irq_request,
   output wire irq_out,
   output wire converter_enable,
   output wire low_power_active,
   output wire sequence_start,
   output reg [3:0] stage_count,
   output reg [8:0] decimation_ratio,
   output wire excitation_gate,
   output wire [1:0] converter_bias_current,
   output reg [6:0] bias_percent,
   output wire [NUM_STAGES-1:0] stage_calibration_enable,
   output reg [5:0] sample_skip
);
   localparam ST_OFF = 3'b001;
   localparam ST_FULL = 3'b010;
   localparam ST_LOW = 3'b100;

   reg [15:0] converter_power_config;
   reg [15:0] stage_calibration_enable_map;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [31:0] load_count;
   wire timer_tick;
   wire [1:0] power_mode;
   wire [1:0] sleep_wake_interval;
   wire irq_output_polarity;
   wire restore_write;

   // Mode field to state
   function [2:0] mode_state;
      input [1:0] mode;
      begin
         case (mode)
            `CPC_MODE_FULL: mode_state = ST_FULL;
            `CPC_MODE_LOW: mode_state = ST_LOW;
            default: mode_state = ST_OFF;
         endcase
      end
   endfunction

   assign power_mode = converter_power_config[`CPC_F_MODE_HI:`CPC_F_MODE_LO];
   assign sleep_wake_interval = converter_power_config[`CPC_F_DELAY_HI:`CPC_F_DELAY_LO];
   assign irq_output_polarity = converter_power_config[`CPC_F_POLARITY];
   assign restore_write = reg_write && (reg_addr == `CPC_ADDR_POWER_CONFIG) && reg_wdata[`CPC_F_RESTORE];

   // Register writes
   always @(posedge clock) begin
      if (rst) begin
         converter_power_config <= `CPC_RESET_POWER_CONFIG;
         stage_calibration_enable_map <= `CPC_RESET_CAL_ENABLE;
      end else if (restore_write) begin
         // (R07) Restore defaults
         converter_power_config <= `CPC_RESET_POWER_CONFIG;
         stage_calibration_enable_map <= `CPC_RESET_CAL_ENABLE;
      end else if (reg_write) begin
         case (reg_addr)
            `CPC_ADDR_POWER_CONFIG: converter_power_config <= reg_wdata & `CPC_POWER_CONFIG_MASK;
            `CPC_ADDR_CAL_ENABLE: stage_calibration_enable_map <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         case (reg_addr)
            `CPC_ADDR_POWER_CONFIG: reg_rdata <= converter_power_config;
            `CPC_ADDR_CAL_ENABLE: reg_rdata <= stage_calibration_enable_map;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Operating state follows the mode field
   always @* begin
      // (R01) Mode decode
      next_state = mode_state(power_mode);
   end

   always @(posedge clock) begin
      if (rst) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Sequence interval per state
   always @* begin
      case (state)
         ST_FULL: load_count = FULL_INTERVAL_CYC;
         // (R04) Wake delay steps
         ST_LOW: load_count = LOW_STEP_CYC * ({30'h0, sleep_wake_interval} + 32'h1);
         default: load_count = 32'h1;
      endcase
   end

   // (R02) Timer halted when off
   cpc_interval_timer #(
      .WIDTH(32)
   ) u_timer (
      .clock(clock),
      .rst(rst),
      .run(state != ST_OFF),
      .load_count(load_count),
      .tick(timer_tick)
   );

   // (R03) Low power wake-up
   assign sequence_start = timer_tick && (state != ST_OFF);
   assign converter_enable = (state != ST_OFF);
   assign low_power_active = (state == ST_LOW);

   // Decoded converter settings
   always @(posedge clock) begin
      if (rst) begin
         stage_count <= 4'h1;
         decimation_ratio <= 9'h100;
         bias_percent <= 7'h00;
      end else begin
         // (R05) Stages plus one, clamped
         if (converter_power_config[`CPC_F_STAGES_HI:`CPC_F_STAGES_LO] > `CPC_MAX_STAGE_CODE) begin
            stage_count <= 4'hc;
         end else begin
            stage_count <= converter_power_config[`CPC_F_STAGES_HI:`CPC_F_STAGES_LO] + 4'h1;
         end
         // (R06) Decimation ratio
         case (converter_power_config[`CPC_F_DECIM_HI:`CPC_F_DECIM_LO])
            2'h0: decimation_ratio <= 9'h100;
            2'h1: decimation_ratio <= 9'h080;
            default: decimation_ratio <= 9'h040;
         endcase
         // (R10) Bias increase
         case (converter_power_config[`CPC_F_BIAS_HI:`CPC_F_BIAS_LO])
            2'h0: bias_percent <= 7'h00;
            2'h1: bias_percent <= 7'h14;
            2'h2: bias_percent <= 7'h23;
            default: bias_percent <= 7'h32;
         endcase
      end
   end

   // Samples skipped for averaging
   always @(posedge clock) begin
      if (rst) begin
         sample_skip <= 6'h03;
      end else if (state == ST_LOW) begin
         // (R13) Low power skip
         case (stage_calibration_enable_map[`CPC_F_LPSKIP_HI:`CPC_F_LPSKIP_LO])
            2'h0: sample_skip <= 6'h00;
            2'h1: sample_skip <= 6'h01;
            default: sample_skip <= 6'h02;
         endcase
      end else begin
         // (R12) Full power skip
         case (stage_calibration_enable_map[`CPC_F_FPSKIP_HI:`CPC_F_FPSKIP_LO])
            2'h0: sample_skip <= 6'h03;
            2'h1: sample_skip <= 6'h07;
            2'h2: sample_skip <= 6'h0f;
            default: sample_skip <= 6'h1f;
         endcase
      end
   end

   // (R08) Interrupt polarity
   assign irq_out = irq_output_polarity ? irq_request : ~irq_request;
   // (R09) Excitation gate
   assign excitation_gate = converter_power_config[`CPC_F_EXC_GATE];
   assign converter_bias_current = converter_power_config[`CPC_F_BIAS_HI:`CPC_F_BIAS_LO];
   // (R11) Per-stage calibration
   assign stage_calibration_enable = stage_calibration_enable_map[NUM_STAGES-1:0];
endmodule // cpc_power_config

// file: testbench/cpc_power_config_sva.sv
// Checker for the power and calibration configuration block
// Sees only the top ports; bound from the testbench top file
`timescale 1ns/1ps
module cpc_power_config_sva (
   input wire clock,
   input wire rst,
   input wire [9:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [15:0] reg_rdata,
   input wire irq_request,
   input wire irq_out,
   input wire converter_enable,
   input wire low_power_active,
   input wire sequence_start,
   input wire [3:0] stage_count,
   input wire [8:0] decimation_ratio,
   input wire excitation_gate,
   input wire [1:0] converter_bias_current,
   input wire [6:0] bias_percent,
   input wire [11:0] stage_calibration_enable,
   input wire [5:0] sample_skip
);
   reg [15:0] p, c, e;
   localparam [27:0] BP = {7'h32, 7'h23, 7'h14, 7'h00};
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Shadow registers and expected read data
   always @(posedge clock) begin
      e <= (reg_addr == 10'h000) ? p : ((reg_addr == 10'h001) ? c : 16'h0000);
      if (rst || (reg_write && reg_addr == 10'h000 && reg_wdata[10])) begin
         p <= 16'h0000;
         c <= 16'h0000;
      end else if (reg_write && reg_addr == 10'h000)
         p <= reg_wdata & 16'hdfff;
      else if (reg_write && reg_addr == 10'h001)
         c <= reg_wdata;
   end
   AST_RDATA: assert property (reg_read |=> reg_rdata == e) else $error("read data");
   AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 16'h0000) else $error("idle read data");
   AST_STAGES: assert property (stage_count == (($past(p[7:4]) > 4'hb) ? 4'hc : $past(p[7:4]) + 4'h1))
      else $error("stage count");
   AST_DECIM: assert property (decimation_ratio == ($past(p[9]) ? 9'h040 : ($past(p[8]) ? 9'h080 : 9'h100)))
      else $error("decimation");
   AST_MODE: assert property (!$past(rst) |-> converter_enable == ($past(p[1:0]) == 2'h0 || $past(p[1:0]) == 2'h2)
      && low_power_active == ($past(p[1:0]) == 2'h2)) else $error("power mode");
   AST_SHUT: assert property (!converter_enable [*3] |-> !sequence_start) else $error("start in shutdown");
   AST_SKIP: assert property (!$past(rst) && $past(p[1:0]) == $past(p[1:0], 2) |-> sample_skip == (($past(p[1:0])
      == 2'h2) ? ($past(c[15]) ? 6'h02 : {5'h00, $past(c[14])}) : (6'h04 << $past(c[13:12])) - 6'h01))
      else $error("sample skip");
   AST_IRQ: assert property (irq_out == (p[11] ? irq_request : !irq_request)) else $error("irq polarity");
   AST_EXC: assert property (excitation_gate == p[12] && converter_bias_current == p[15:14])
      else $error("gate or bias field");
   AST_PCT: assert property (bias_percent == BP[$past(p[15:14]) * 7 +: 7]) else $error("bias percent");
   AST_CAL: assert property (stage_calibration_enable == c[11:0]) else $error("calibration enables");
   // Main scenarios reached
   COV_LOW: cover property (low_power_active && sequence_start);
   COV_MAX: cover property (stage_count == 4'hc);
   COV_RD: cover property (reg_read && reg_addr == 10'h001);
endmodule // cpc_power_config_sva

// file: testbench/testbench.sv
// Self-checking bench for the power and calibration configuration block
// Assumes short timer parameters so that sequence gaps are brief
`timescale 1ns/1ps
module testbench;
   reg clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, irq_request = 1'b0;
   reg [9:0] reg_addr = 10'h000;
   reg [15:0] reg_wdata = 16'h0000, seed = 16'h414f, ri = 16'h414f, d;
   wire [15:0] reg_rdata;
   wire [3:0] stage_count;
   wire sequence_start;
   integer n_errors = 0, n_tests = 0, k, n;
   cpc_power_config #(.FULL_INTERVAL_CYC(20), .LOW_STEP_CYC(10)) u_cpc_power_config (.clock(clock), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .irq_request(irq_request), .irq_out(), .converter_enable(), .low_power_active(),
      .sequence_start(sequence_start), .stage_count(stage_count), .decimation_ratio(), .excitation_gate(),
      .converter_bias_current(), .bias_percent(), .stage_calibration_enable(), .sample_skip());
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [3:0] exp_st(input [3:0] f);
      exp_st = (f > 4'hb) ? 4'hc : f + 4'h1;
   endfunction
   task check(input [15:0] g, input [15:0] x);
      begin
         n_tests = n_tests + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
         end
      end
   endtask
   task wr(input [9:0] a, input [15:0] x);
      begin
         @(posedge clock);
         reg_write <= 1'b1;
         reg_addr <= a;
         reg_wdata <= x;
         @(posedge clock);
         reg_write <= 1'b0;
      end
   endtask
   task rd(input [9:0] a, input [15:0] x);
      begin
         @(posedge clock);
         reg_read <= 1'b1;
         reg_addr <= a;
         @(posedge clock);
         reg_read <= 1'b0;
         #1 check(reg_rdata, x);
      end
   endtask
   // Cycles between the next two sequence starts
   task gap(input [15:0] x);
      begin
         n = 0;
         while (!sequence_start && n < 500) begin
            @(posedge clock);
            #1 n = n + 1;
         end
         n = 0;
         do begin
            @(posedge clock);
            #1 n = n + 1;
         end while (!sequence_start && n < 500);
         check(n[15:0], x);
      end
   endtask
   task print_verdict;
      begin
         if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      forever #5 clock = ~clock;
   end
   // Random interrupt request
   always @(posedge clock) begin
      ri <= lfsr(ri);
      irq_request <= ri[0];
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_errors = n_errors + 1;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rd(10'h000, 16'h0000);
      rd(10'h001, 16'h0000);
      gap(16'd20);
      for (k = 0; k < 4; k = k + 1) begin
         wr(10'h000, k[0] ? 16'h0003 : 16'h0001);
         repeat (3) @(posedge clock);
         n = 0;
         repeat (40) @(posedge clock) #1 n = n + sequence_start;
         check(n[15:0], 16'h0000);
         wr(10'h000, {12'h000, k[1:0], 2'b10});
         gap(16'd10 * (k[15:0] + 16'd1));
      end
      for (k = 0; k < 24; k = k + 1) begin
         seed = lfsr(seed);
         wr(10'h001, seed);
         rd(10'h001, seed);
         d = lfsr(seed) & 16'hfbff;
         wr(10'h000, d);
         rd(10'h000, d & 16'hdfff);
         check({12'h000, stage_count}, {12'h000, exp_st(d[7:4])});
      end
      wr(10'h000, 16'h00b0);
      rd(10'h000, 16'h00b0);
      check({12'h000, stage_count}, 16'h000c);
      wr(10'h001, 16'hffff);
      wr(10'h000, 16'h0cff);
      wr(10'h002, 16'hffff);
      rd(10'h000, 16'h0000);
      rd(10'h001, 16'h0000);
      rd(10'h002, 16'h0000);
      print_verdict;
   end
endmodule // testbench
bind cpc_power_config cpc_power_config_sva u_cpc_power_config_sva (.*);
